//--- include/pg_seq_defs.svh
// constants for power-good and turn-on delay sequencing
// How it works
// - power good sets above threshold, clears below limit
// - threshold is paged sixteen-bit unsigned protectable word
// - threshold resets to nine tenths of target
// - enable waits programmed delay before ramp
// - delay is paged linear-11 protectable word
// - delay resets to ca80, five milliseconds
// - ramp starts after enable and delay expiry
`ifndef PG_SEQ_DEFS_SVH
`define PG_SEQ_DEFS_SVH
`define OFS_POWER_GOOD_THRESHOLD 8'h5e
`define OFS_TURN_ON_DELAY        8'h60
`define TURN_ON_DELAY_RESET      16'hca80
`define EXP_MSB                  15
`define EXP_LSB                  11
`define MANT_MSB                 10
`define CLOCK_MHZ                250
`define CYCLES_PER_MS            (`CLOCK_MHZ * 1000)
`define MAX_DELAY_MS             5000
`define STRAP_SCALE_NUM          32'h9
`define STRAP_SCALE_DEN          32'ha
`endif

//--- include/pg_seq_pkg.sv
// types for power-good and turn-on delay sequencing
package pg_seq_pkg;
  typedef enum logic [1:0] {
    st_off,
    st_wait,
    st_ramp
  } seq_state_t;
  typedef struct packed {
    logic [1:0][15:0] threshold;
    logic [1:0][15:0] delay;
    logic [1:0][1:0]  state;
    logic [1:0][31:0] count;
    logic [1:0]       power_good;
    logic [1:0]       ramp_start;
    logic [15:0]      read_data;
    logic             strap_loaded;
  } pg_state_t;
endpackage : pg_seq_pkg

//--- hw/power_good_and_turn_on_delay.sv
// paged power-good detector and turn-on delay sequencer
`timescale 1ns/100ps
`default_nettype none
`include "pg_seq_defs.svh"
module power_good_and_turn_on_delay
  import pg_seq_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             page,
  input  wire logic             write_strobe,
  input  wire logic [7:0]       command_code,
  input  wire logic [15:0]      write_data,
  input  wire logic             write_protect,
  input  wire logic [1:0][15:0] output_target_voltage,
  input  wire logic [1:0][15:0] output_undervolt_limit,
  input  wire logic [1:0][15:0] output_voltage,
  input  wire logic [1:0]       enable,
  output logic      [15:0]      read_data,
  output logic      [1:0]       power_good,
  output logic      [1:0]       ramp_start
);
  pg_state_t cur;
  pg_state_t next_cur;

  logic       write_allowed;
  logic       hit_threshold;
  logic       hit_delay;
  // write decode, one bit per page
  logic [1:0] write_threshold;
  logic [1:0] write_delay;
  logic [1:0] good_level;

  function automatic logic signed [4:0] delay_exponent(input logic [15:0] word);
    return word[`EXP_MSB:`EXP_LSB];
  endfunction : delay_exponent

  function automatic logic signed [10:0] delay_mantissa(input logic [15:0] word);
    return word[`MANT_MSB:0];
  endfunction : delay_mantissa

  // linear-11 delay in clock cycles, negative values clamp to zero
  function automatic logic [31:0] delay_cycles(input logic [15:0] word);
    logic signed [4:0]  exponent;
    logic signed [10:0] mantissa;
    logic [63:0]        cycles;
    logic [63:0]        ceiling;

    exponent = delay_exponent(word);
    mantissa = delay_mantissa(word);
    ceiling = 64'(`MAX_DELAY_MS) * 64'(`CYCLES_PER_MS);
    cycles = 64'h0;
    if (mantissa > 0) begin
      cycles = 64'(mantissa) * 64'(`CYCLES_PER_MS);
      // negative exponent divides, dropping the fraction
      if (exponent < 0) begin
        cycles = cycles >> (-exponent);
      end else begin
        cycles = cycles << exponent;
      end
      if (cycles > ceiling) begin
        cycles = ceiling;
      end
    end
    return cycles[31:0];
  endfunction : delay_cycles

  // strapped default, floor of nine tenths of the target
  function automatic logic [15:0] strap_threshold(input logic [15:0] target);
    logic [31:0] scaled;

    scaled = (32'(target) * `STRAP_SCALE_NUM) / `STRAP_SCALE_DEN;
    return scaled[15:0];
  endfunction : strap_threshold

  // set above threshold wins over clear below limit
  function automatic logic next_good(
    input logic        good,
    input logic [15:0] voltage,
    input logic [15:0] threshold,
    input logic [15:0] limit
  );
    logic result;

    result = good;
    if (voltage > threshold) begin
      result = 1'b1;
    end else if (voltage < limit) begin
      result = 1'b0;
    end
    return result;
  endfunction : next_good

  // register read mux, unknown codes read as zero
  function automatic logic [15:0] read_select(
    input logic [7:0]       code,
    input logic             sel,
    input logic [1:0][15:0] thresholds,
    input logic [1:0][15:0] delays
  );
    logic [15:0] value;

    value = 16'h0000;
    if (code == `OFS_POWER_GOOD_THRESHOLD) begin
      value = thresholds[sel];
    end else if (code == `OFS_TURN_ON_DELAY) begin
      value = delays[sel];
    end
    return value;
  endfunction : read_select

  // one page of the off, wait, ramp sequence
  function automatic void seq_step(
    input  logic        on,
    input  logic [1:0]  state_in,
    input  logic [31:0] count_in,
    input  logic [15:0] delay_word,
    output logic [1:0]  state_out,
    output logic [31:0] count_out,
    output logic        start_out
  );
    state_out = state_in;
    count_out = count_in;
    start_out = 1'b0;
    // enable low abandons a wait or ramp at once
    if (!on) begin
      state_out = st_off;
      count_out = 32'h0;
    end else begin
      unique case (seq_state_t'(state_in))
        st_off: begin
          // delay latched as the page is enabled
          state_out = st_wait;
          count_out = delay_cycles(delay_word);
        end
        st_wait: begin
          if (count_in == 32'h0) begin
            state_out = st_ramp;
            start_out = 1'b1;
          end else begin
            count_out = count_in - 32'h1;
          end
        end
        st_ramp: begin
          state_out = st_ramp;
        end
        default: begin
          state_out = st_off;
        end
      endcase
    end
  endfunction : seq_step

  // writes refused while protected or before strap load
  assign write_allowed = write_strobe && !write_protect && cur.strap_loaded;
  assign hit_threshold = (command_code == `OFS_POWER_GOOD_THRESHOLD);
  assign hit_delay     = (command_code == `OFS_TURN_ON_DELAY);

  // per-page write decode and power-good level
  for (genvar g = 0; g < 2; g++) begin : g_page
    assign write_threshold[g] = write_allowed && hit_threshold && (page == 1'(g));
    assign write_delay[g]     = write_allowed && hit_delay && (page == 1'(g));
    // set above threshold, clear below limit
    assign good_level[g]      = next_good(cur.power_good[g], output_voltage[g],
                                          cur.threshold[g], output_undervolt_limit[g]);
  end

  always_comb begin
    next_cur = cur;

    if (!cur.strap_loaded) begin
      for (int p = 0; p < 2; p++) begin
        next_cur.threshold[p] = strap_threshold(output_target_voltage[p]);
      end
      next_cur.strap_loaded = 1'b1;
    end

    // read back one cycle after the code
    next_cur.read_data = read_select(command_code, page, cur.threshold, cur.delay);

    for (int p = 0; p < 2; p++) begin
      if (write_threshold[p]) begin
        next_cur.threshold[p] = write_data;
      end
      if (write_delay[p]) begin
        next_cur.delay[p] = write_data;
      end
      if (cur.strap_loaded) begin
        next_cur.power_good[p] = good_level[p];
      end
      seq_step(enable[p], cur.state[p], cur.count[p], cur.delay[p],
               next_cur.state[p], next_cur.count[p], next_cur.ramp_start[p]);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cur <= '0;
      cur.delay <= {`TURN_ON_DELAY_RESET, `TURN_ON_DELAY_RESET};
    end else begin
      cur <= next_cur;
    end
  end

  // outputs straight from the state register
  assign read_data  = cur.read_data;
  assign power_good = cur.power_good;
  assign ramp_start = cur.ramp_start;
endmodule : power_good_and_turn_on_delay
`default_nettype wire

//--- test/pg_seq_assertions.sv
// checker for power good and turn-on delay ports
`timescale 1ns/100ps
`default_nettype none
module pg_seq_assertions (
  input wire logic             clock,
  input wire logic             rst_n,
  input wire logic             page,
  input wire logic             write_strobe,
  input wire logic             write_protect,
  input wire logic [7:0]       command_code,
  input wire logic [15:0]      write_data,
  input wire logic [15:0]      read_data,
  input wire logic [1:0][15:0] output_undervolt_limit,
  input wire logic [1:0][15:0] output_voltage,
  input wire logic [1:0]       enable,
  input wire logic [1:0]       power_good,
  input wire logic [1:0]       ramp_start
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  pg_fall_a: assert property ($fell(power_good[0]) |->
    $past(output_voltage[0] < output_undervolt_limit[0])) else $error("good fell early");
  pg_hold_a: assert property (power_good[0] && output_voltage[0] >=
    output_undervolt_limit[0] |=> power_good[0]) else $error("good dropped");
  pg_clear_a: assert property (power_good[0] && output_voltage[0] <
    output_undervolt_limit[0] |=> !power_good[0]) else $error("good held");
  ramp_pulse_a: assert property (ramp_start[0] |=> !ramp_start[0])
    else $error("ramp pulse long");
  ramp_enable_a: assert property (ramp_start[1] |-> $past(enable[1]))
    else $error("ramp without enable");
  ramp_idle_a: assert property (!enable[0] |=> !ramp_start[0])
    else $error("ramp while off");
  write_read_a: assert property ($past(write_strobe && !write_protect) &&
    $stable(command_code) && $stable(page) && command_code inside {8'h5e, 8'h60}
    |=> read_data == $past(write_data, 2)) else $error("readback wrong");
  unknown_read_a: assert property (!(command_code inside {8'h5e, 8'h60})
    |=> read_data == 16'h0000) else $error("unknown code read");
endmodule : pg_seq_assertions
bind power_good_and_turn_on_delay pg_seq_assertions u_pg_seq_assertions (
  .clock                  (clock),
  .rst_n                  (rst_n),
  .page                   (page),
  .write_strobe           (write_strobe),
  .write_protect          (write_protect),
  .command_code           (command_code),
  .write_data             (write_data),
  .read_data              (read_data),
  .output_undervolt_limit (output_undervolt_limit),
  .output_voltage         (output_voltage),
  .enable                 (enable),
  .power_good             (power_good),
  .ramp_start             (ramp_start)
);
`default_nettype wire

//--- test/pg_host.sv
// host model issuing register writes and reads
`timescale 1ns/100ps
`default_nettype none
module pg_host (
  input  wire logic        clock,
  output logic             page,
  output logic             write_strobe,
  output logic             chk,
  output logic [7:0]       command_code,
  output logic [15:0]      write_data
);
  logic [15:0] q[$];
  initial {page, write_strobe, chk, command_code, write_data} = '0;
  task automatic wr(input logic p, input logic [7:0] c, input logic [15:0] d);
    @(posedge clock) #1 {page, command_code, write_data, write_strobe} = {p, c, d, 1'b1};
    @(posedge clock) #1 write_strobe = 0;
  endtask : wr
  task automatic rd(input logic p, input logic [7:0] c, input logic [15:0] e);
    @(posedge clock) #1 {page, command_code} = {p, c};
    @(posedge clock) #1 chk = 1;
    q.push_back(e);
    @(posedge clock) #1 chk = 0;
  endtask : rd
endmodule : pg_host
`default_nettype wire

//--- test/power_good_and_turn_on_delay_tb.sv
// self-checking bench for power good and turn-on delay
`timescale 1ns/100ps
`default_nettype none
module power_good_and_turn_on_delay_tb;
  logic clock = 0, rst_n = 0, write_protect = 0, chk, page, write_strobe;
  logic [7:0] command_code;
  logic [15:0] write_data, read_data, d;
  logic [1:0][15:0] output_target_voltage, output_undervolt_limit, output_voltage;
  logic [1:0] enable = 0, power_good, ramp_start;
  logic [15:0] v[4] = '{16'h0352, 16'h03e8, 16'h0352, 16'h0300};
  int n_errors = 0, samples_checked = 0;
  logic pg_chk = 0;
  logic [15:0] pg_q[$];
  always #2 clock = ~clock;
  pg_host u_pg_host (.clock(clock), .page(page), .write_strobe(write_strobe), .chk(chk),
    .command_code(command_code), .write_data(write_data));
  power_good_and_turn_on_delay u_power_good_and_turn_on_delay (.clock(clock), .rst_n(rst_n),
    .page(page), .write_strobe(write_strobe), .command_code(command_code),
    .write_data(write_data), .write_protect(write_protect),
    .output_target_voltage(output_target_voltage), .output_voltage(output_voltage),
    .output_undervolt_limit(output_undervolt_limit), .enable(enable),
    .read_data(read_data), .power_good(power_good), .ramp_start(ramp_start));
  task automatic cmp(input string w, input logic [15:0] e, input logic [15:0] s);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", w, e, s);
    end
  endtask : cmp
  task automatic conclude;
    $display("mismatches %0d comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  task automatic ramp(input int p, input int lo);
    int k;
    @(posedge clock) #1 enable[p] = 1;
    for (k = 0; k < lo + 9 && ramp_start[p] !== 1'b1; k++) @(posedge clock) #1;
    cmp("ramp_wait", 16'h0001, 16'(k >= lo && k <= lo + 4));
    if (k >= lo + 9) conclude();
    enable[p] = 0;
    $display("ramp test done");
  endtask : ramp
  always @(posedge clock) if (chk) cmp("read_data", u_pg_host.q.pop_front(), read_data);
  always @(posedge clock) if (pg_chk) cmp("power_good", pg_q.pop_front(), 16'(power_good));
  initial begin
    void'($urandom(32'h09327fe8));
    output_target_voltage = {16'h07d0, 16'h03e8};
    output_undervolt_limit = {2{16'h0320}};
    output_voltage = '0;
    repeat (10) @(posedge clock);
    #1 rst_n = 1;
    u_pg_host.rd(0, 8'h5e, 16'h0384);
    u_pg_host.rd(1, 8'h5e, 16'h0708);
    u_pg_host.rd(1, 8'h60, 16'hca80);
    u_pg_host.rd(0, 8'h61, 16'h0000);
    write_protect = 1;
    u_pg_host.wr(0, 8'h60, 16'h0000);
    write_protect = 0;
    u_pg_host.rd(0, 8'h60, 16'hca80);
    d = 16'($urandom);
    u_pg_host.wr(1, 8'h5e, d);
    u_pg_host.rd(1, 8'h5e, d);
    u_pg_host.wr(0, 8'h60, 16'hf001);
    u_pg_host.rd(0, 8'h60, 16'hf001);
    $display("register test done");
    for (int i = 0; i < 4; i++) begin
      output_voltage[0] = v[i];
      repeat (3) @(posedge clock) #1;
      pg_q.push_back(16'(i == 1 || i == 2));
      pg_chk = 1;
      @(posedge clock) #1 pg_chk = 0;
    end
    $display("power good test done");
    ramp(0, 62500);
    u_pg_host.wr(1, 8'h60, 16'h0400);
    ramp(1, 0);
    conclude();
  end
  initial begin
    #400000;
    n_errors++;
    conclude();
  end
endmodule : power_good_and_turn_on_delay_tb
`default_nettype wire
